// [include/pmcs_consts.vh]
`ifndef PMCS_CONSTS_VH
`define PMCS_CONSTS_VH

// register byte offsets
`define PMCS_GEN_CFG_OFF 8'h00
`define PMCS_ADC_CFG_OFF 8'h04
`define PMCS_DIAG_OFF 8'h08
`define PMCS_CUR_OFF 8'h0C
`define PMCS_VBUS_OFF 8'h10
`define PMCS_TEMP_OFF 8'h14
`define PMCS_PWR_OFF 8'h18
`define PMCS_ENERGY_OFF 8'h1C
`define PMCS_CHARGE_OFF 8'h20

// general setup fields
`define PMCS_GEN_SRST_BIT 15
`define PMCS_GEN_DLY_MSB 13
`define PMCS_GEN_DLY_LSB 6
`define PMCS_GEN_CFG_RST 8'h00

// adc setup fields
`define PMCS_ADC_MODE_MSB 14
`define PMCS_ADC_MODE_LSB 12
`define PMCS_ADC_BCT_LSB 9
`define PMCS_ADC_SCT_LSB 6
`define PMCS_ADC_TCT_LSB 3
`define PMCS_ADC_AVG_LSB 0
`define PMCS_ADC_CFG_RST 15'h7B68

// diagnostic bits
`define PMCS_DIAG_READY_BIT 1
`define PMCS_DIAG_MATHOF_BIT 2
`define PMCS_DIAG_CHGOF_BIT 3
`define PMCS_DIAG_ENGOF_BIT 4
`define PMCS_DIAG_INVAL_BIT 5

// timing
`define PMCS_CLK_PERIOD_NS 10
`define PMCS_US_NS 1000
`define PMCS_CYC_PER_US (`PMCS_US_NS / `PMCS_CLK_PERIOD_NS)
`define PMCS_MS_US 1000
`define PMCS_DLY_STEP_MS 2
`define PMCS_CT0_US 13'd50
`define PMCS_CT1_US 13'd84
`define PMCS_CT2_US 13'd150
`define PMCS_CT3_US 13'd280
`define PMCS_CT4_US 13'd540
`define PMCS_CT5_US 13'd1052
`define PMCS_CT6_US 13'd2074
`define PMCS_CT7_US 13'd4120

`endif

// [hw/pmcs_avg.v]
`timescale 1ns/1ps
`default_nettype none

module pmcs_avg #(
    parameter DW = 20
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire clr,
    input wire add,
    input wire [3:0] shift,
    // data
    input wire signed [DW-1:0] sample,
    output wire signed [DW-1:0] avg
);

reg signed [DW+9:0] sum_reg;
wire signed [DW+9:0] shifted;

assign shifted = sum_reg >>> shift;
assign avg = shifted[DW-1:0];

// headroom of ten bits covers the largest count
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        sum_reg <= {(DW+10){1'b0}};
    end else if (clr) begin
        sum_reg <= {(DW+10){1'b0}};
    end else if (add) begin
        sum_reg <= sum_reg + {{10{sample[DW-1]}}, sample};
    end
end

endmodule // pmcs_avg

`default_nettype wire

// [hw/pmcs_seq.v]
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_consts.vh"

module pmcs_seq #(
    parameter DW = 20,
    parameter [15:0] CYC_PER_US = `PMCS_CYC_PER_US,
    parameter [15:0] US_PER_MS = `PMCS_MS_US,
    parameter signed [7:0] TC_COEF = 8'sh10,
    parameter signed [DW-1:0] T_REF = {DW{1'b0}}
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // converter front end
    output reg conv_start,
    output reg [1:0] conv_channel,
    output reg [2:0] conv_period,
    output wire conv_busy,
    input wire signed [DW-1:0] adc_data,
    // status
    output wire conversion_ready_flag
);

localparam S_OFF = 3'h0;
localparam S_DLY = 3'h1;
localparam S_TMP = 3'h2;
localparam S_SHN = 3'h3;
localparam S_BUS = 3'h4;

function [12:0] conv_us;
    input [2:0] code;
    begin
        case (code)
            3'h0: conv_us = `PMCS_CT0_US;
            3'h1: conv_us = `PMCS_CT1_US;
            3'h2: conv_us = `PMCS_CT2_US;
            3'h3: conv_us = `PMCS_CT3_US;
            3'h4: conv_us = `PMCS_CT4_US;
            3'h5: conv_us = `PMCS_CT5_US;
            3'h6: conv_us = `PMCS_CT6_US;
            default: conv_us = `PMCS_CT7_US;
        endcase
    end
endfunction

function [3:0] avg_shift;
    input [2:0] code;
    begin
        case (code)
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            default: avg_shift = 4'hA;
        endcase
    end
endfunction

function reg_hit;
    input [7:0] a;
    begin
        reg_hit = (a <= `PMCS_CHARGE_OFF) && (a[1:0] == 2'h0);
    end
endfunction

// returns overflow bit above the saturated-hold sum
function [32:0] sat_add;
    input [31:0] a;
    input [31:0] b;
    reg [31:0] s;
    begin
        s = a + b;
        if ((a[31] == b[31]) && (s[31] != a[31])) begin
            sat_add = {1'b1, a};
        end else begin
            sat_add = {1'b0, s};
        end
    end
endfunction

reg [2:0] state_reg;
reg [2:0] state_next;
reg [7:0] dly_reg;
reg [14:0] adc_cfg_reg;
reg srst_reg;
reg [15:0] us_cnt_reg;
reg [15:0] ms_div_reg;
reg [8:0] dly_ms_reg;
reg [12:0] ct_cnt_reg;
reg [10:0] smp_cnt_reg;
reg signed [DW-1:0] tmp_last_reg;
reg signed [DW-1:0] cur_inst_reg;
reg signed [DW-1:0] vb_inst_reg;
reg signed [DW-1:0] cur_out_reg;
reg signed [DW-1:0] vb_out_reg;
reg signed [DW-1:0] tmp_out_reg;
reg [31:0] pwr_out_reg;
reg [31:0] energy_reg;
reg [31:0] charge_reg;
reg load_pend_reg;
reg pwr_pend_reg;
reg acc_pend_reg;
reg ready_reg;
reg mathof_reg;
reg engof_reg;
reg chgof_reg;
reg [31:0] rd_mux;
reg [2:0] ct_code;
reg conv_end;
reg pass_last;
reg seq_last;
reg enter_conv;

wire [2:0] mode = adc_cfg_reg[`PMCS_ADC_MODE_MSB:`PMCS_ADC_MODE_LSB];
wire cont = mode[2];
wire shn_en = mode[1];
wire bus_en = mode[0];
wire wr = psel & penable & pwrite;
wire rd = psel & penable & ~pwrite;
wire mode_wr = wr & (paddr == `PMCS_ADC_CFG_OFF);
wire [2:0] new_mode = pwdata[`PMCS_ADC_MODE_MSB:`PMCS_ADC_MODE_LSB];
wire new_active = new_mode[1] | new_mode[0];
wire tick_us = (us_cnt_reg == CYC_PER_US - 16'h0001);
wire tick_ms = tick_us & (ms_div_reg == US_PER_MS - 16'h0001);
wire [8:0] dly_target = {dly_reg, 1'b0};
wire in_conv = (state_reg == S_TMP) | (state_reg == S_SHN) | (state_reg == S_BUS);
wire [3:0] sh = avg_shift(adc_cfg_reg[2:0]);
wire [10:0] avg_last = (11'h001 << sh) - 11'h001;
wire [2:0] first_st = shn_en ? S_TMP : S_BUS;
wire sclr = srst_reg;
wire signed [DW:0] t_diff = {tmp_last_reg[DW-1], tmp_last_reg} - {T_REF[DW-1], T_REF};
wire signed [DW+8:0] t_prod = t_diff * TC_COEF;
wire signed [DW+8:0] t_adj = t_prod >>> 8;
wire signed [DW-1:0] cur_comp = adc_data - t_adj[DW-1:0];
wire signed [2*DW-1:0] pwr_avg = cur_out_reg * vb_out_reg;
wire signed [2*DW-1:0] pwr_inst = cur_inst_reg * vb_inst_reg;
wire [32:0] eng_sum = sat_add(energy_reg, pwr_inst[2*DW-1:2*DW-32]);
wire [32:0] chg_sum = sat_add(charge_reg, {{(32-DW){cur_inst_reg[DW-1]}}, cur_inst_reg});
wire signed [DW-1:0] avg_val [0:2];
wire [2:0] add_vec;

assign pready = 1'b1;
assign pslverr = psel & penable & ~reg_hit(paddr);
assign conv_busy = in_conv;
assign conversion_ready_flag = ready_reg;

// next state of the conversion sequencer
always @* begin
    state_next = state_reg;
    case (state_reg)
        S_TMP: ct_code = adc_cfg_reg[`PMCS_ADC_TCT_LSB+2:`PMCS_ADC_TCT_LSB];
        S_SHN: ct_code = adc_cfg_reg[`PMCS_ADC_SCT_LSB+2:`PMCS_ADC_SCT_LSB];
        default: ct_code = adc_cfg_reg[`PMCS_ADC_BCT_LSB+2:`PMCS_ADC_BCT_LSB];
    endcase
    conv_end = in_conv & tick_us & (ct_cnt_reg == conv_us(ct_code) - 13'h0001);
    // current pass ends after bus, or after shunt when bus is off
    pass_last = conv_end & ((state_reg == S_BUS) | ((state_reg == S_SHN) & ~bus_en));
    seq_last = pass_last & (smp_cnt_reg == avg_last);
    case (state_reg)
        S_OFF: state_next = S_OFF;
        S_DLY: if (dly_ms_reg == dly_target) state_next = first_st;
        S_TMP: if (conv_end) state_next = S_SHN;
        S_SHN: if (conv_end) state_next = bus_en ? S_BUS :
            ((seq_last & ~cont) ? S_OFF : first_st);
        S_BUS: if (conv_end) state_next = (seq_last & ~cont) ? S_OFF : first_st;
        default: state_next = S_OFF;
    endcase
    if (mode_wr) state_next = new_active ? S_DLY : S_OFF;
    enter_conv = ((state_next == S_TMP) | (state_next == S_SHN) | (state_next == S_BUS)) &
        ((state_next != state_reg) | conv_end);
end

// register read mux; value captured in setup; only a status read touches the sequencer, by clearing ready_reg
always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
        `PMCS_GEN_CFG_OFF: rd_mux = {18'h00000, dly_reg, 6'h00};
        `PMCS_ADC_CFG_OFF: rd_mux = {17'h00000, adc_cfg_reg};
        `PMCS_DIAG_OFF: rd_mux = {26'h0000000, ~cont & (shn_en | bus_en), engof_reg,
            chgof_reg, mathof_reg, ready_reg, 1'b0};
        `PMCS_CUR_OFF: rd_mux = {{(32-DW){cur_out_reg[DW-1]}}, cur_out_reg};
        `PMCS_VBUS_OFF: rd_mux = {{(32-DW){vb_out_reg[DW-1]}}, vb_out_reg};
        `PMCS_TEMP_OFF: rd_mux = {{(32-DW){tmp_out_reg[DW-1]}}, tmp_out_reg};
        `PMCS_PWR_OFF: rd_mux = pwr_out_reg;
        `PMCS_ENERGY_OFF: rd_mux = energy_reg;
        `PMCS_CHARGE_OFF: rd_mux = charge_reg;
        default: rd_mux = 32'h0000_0000;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
        srst_reg <= 1'b0;
        dly_reg <= `PMCS_GEN_CFG_RST;
        adc_cfg_reg <= `PMCS_ADC_CFG_RST;
        us_cnt_reg <= 16'h0000;
    end else begin
        if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
        end
        us_cnt_reg <= tick_us ? 16'h0000 : us_cnt_reg + 16'h0001;
        srst_reg <= 1'b0;
        if (sclr) begin
            dly_reg <= `PMCS_GEN_CFG_RST;
            adc_cfg_reg <= `PMCS_ADC_CFG_RST;
        end else if (wr & (paddr == `PMCS_GEN_CFG_OFF)) begin
            srst_reg <= pwdata[`PMCS_GEN_SRST_BIT];
            dly_reg <= pwdata[`PMCS_GEN_DLY_MSB:`PMCS_GEN_DLY_LSB];
        end else if (mode_wr) begin
            adc_cfg_reg <= pwdata[14:0];
        end
    end
end

// sequencer and front-end control
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= S_DLY;
        ms_div_reg <= 16'h0000;
        dly_ms_reg <= 9'h000;
        ct_cnt_reg <= 13'h0000;
        smp_cnt_reg <= 11'h000;
        conv_start <= 1'b0;
        conv_channel <= 2'h0;
        conv_period <= 3'h0;
    end else if (sclr) begin
        state_reg <= S_DLY;
        ms_div_reg <= 16'h0000;
        dly_ms_reg <= 9'h000;
        ct_cnt_reg <= 13'h0000;
        smp_cnt_reg <= 11'h000;
        conv_start <= 1'b0;
    end else begin
        state_reg <= state_next;
        conv_start <= enter_conv;
        if (enter_conv) begin
            conv_channel <= state_next[1:0];
            case (state_next)
                S_TMP: conv_period <= adc_cfg_reg[`PMCS_ADC_TCT_LSB+2:`PMCS_ADC_TCT_LSB];
                S_SHN: conv_period <= adc_cfg_reg[`PMCS_ADC_SCT_LSB+2:`PMCS_ADC_SCT_LSB];
                default: conv_period <= adc_cfg_reg[`PMCS_ADC_BCT_LSB+2:`PMCS_ADC_BCT_LSB];
            endcase
        end
        if (mode_wr) begin
            ms_div_reg <= 16'h0000;
            dly_ms_reg <= 9'h000;
        end else if (state_reg == S_DLY & tick_us) begin
            ms_div_reg <= tick_ms ? 16'h0000 : ms_div_reg + 16'h0001;
            if (tick_ms) dly_ms_reg <= dly_ms_reg + 9'h001;
        end
        if (enter_conv) begin
            ct_cnt_reg <= 13'h0000;
        end else if (in_conv & tick_us) begin
            ct_cnt_reg <= ct_cnt_reg + 13'h0001;
        end
        if (mode_wr | seq_last) begin
            smp_cnt_reg <= 11'h000;
        end else if (pass_last) begin
            smp_cnt_reg <= smp_cnt_reg + 11'h001;
        end
    end
end

assign add_vec = {conv_end & (state_reg == S_BUS), conv_end & (state_reg == S_SHN),
    conv_end & (state_reg == S_TMP)};

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_avg
        pmcs_avg #(
            .DW(DW)
        ) u_avg (
            .clk(pclk),
            .rst_n(presetn),
            .clr(sclr | mode_wr | load_pend_reg),
            .add(add_vec[gi]),
            .shift(sh),
            .sample(gi == 0 ? adc_data : (gi == 1 ? cur_comp : adc_data)),
            .avg(avg_val[gi])
        );
    end
endgenerate

// results, background arithmetic and flags
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tmp_last_reg <= {DW{1'b0}};
        cur_inst_reg <= {DW{1'b0}};
        vb_inst_reg <= {DW{1'b0}};
        cur_out_reg <= {DW{1'b0}};
        vb_out_reg <= {DW{1'b0}};
        tmp_out_reg <= {DW{1'b0}};
        pwr_out_reg <= 32'h0000_0000;
        energy_reg <= 32'h0000_0000;
        charge_reg <= 32'h0000_0000;
        load_pend_reg <= 1'b0;
        pwr_pend_reg <= 1'b0;
        acc_pend_reg <= 1'b0;
        ready_reg <= 1'b0;
        mathof_reg <= 1'b0;
        engof_reg <= 1'b0;
        chgof_reg <= 1'b0;
    end else if (sclr) begin
        cur_out_reg <= {DW{1'b0}};
        vb_out_reg <= {DW{1'b0}};
        tmp_out_reg <= {DW{1'b0}};
        pwr_out_reg <= 32'h0000_0000;
        energy_reg <= 32'h0000_0000;
        charge_reg <= 32'h0000_0000;
        load_pend_reg <= 1'b0;
        pwr_pend_reg <= 1'b0;
        acc_pend_reg <= 1'b0;
        ready_reg <= 1'b0;
        mathof_reg <= 1'b0;
        engof_reg <= 1'b0;
        chgof_reg <= 1'b0;
    end else begin
        if (add_vec[0]) tmp_last_reg <= adc_data;
        if (add_vec[1]) cur_inst_reg <= cur_comp;
        if (add_vec[2]) vb_inst_reg <= adc_data;
        load_pend_reg <= seq_last & ~mode_wr;
        pwr_pend_reg <= load_pend_reg;
        acc_pend_reg <= pass_last & ~mode_wr;
        // shift of zero passes sample unchanged
        if (load_pend_reg) begin
            if (shn_en) begin
                tmp_out_reg <= avg_val[0];
                cur_out_reg <= avg_val[1];
            end
            if (bus_en) vb_out_reg <= avg_val[2];
        end
        // power from averaged current and voltage
        if (pwr_pend_reg) pwr_out_reg <= pwr_avg[2*DW-1:2*DW-32];
        if (acc_pend_reg) begin
            energy_reg <= eng_sum[31:0];
            charge_reg <= chg_sum[31:0];
            if (eng_sum[32]) engof_reg <= 1'b1;
            if (chg_sum[32]) chgof_reg <= 1'b1;
            if (eng_sum[32] | chg_sum[32]) mathof_reg <= 1'b1;
        end
        // set after full sequence; clears, set wins
        if (pwr_pend_reg) begin
            ready_reg <= 1'b1;
        end else if ((mode_wr & new_active) | (rd & (paddr == `PMCS_DIAG_OFF))) begin
            ready_reg <= 1'b0;
        end
    end
end

endmodule // pmcs_seq

`default_nettype wire

// [verification/pmcs_seq_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_consts.vh"
module pmcs_seq_asserts #(
    parameter [15:0] CYC_PER_US = 16'(`PMCS_CYC_PER_US),
    parameter [15:0] US_PER_MS = 16'(`PMCS_MS_US)
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // converter and status
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    input wire logic [2:0] conv_period,
    input wire logic conv_busy,
    input wire logic conversion_ready_flag
);
    localparam int DLY_CYC = 2 * US_PER_MS * CYC_PER_US;
    wire acc = psel && penable;
    wire wr_adc = acc && pwrite && paddr == `PMCS_ADC_CFG_OFF;
    wire wr_run = wr_adc && pwdata[13:12] != 2'h0;
    wire wr_sd = wr_adc && pwdata[13:12] == 2'h0;
    wire rd_diag = acc && !pwrite && paddr == `PMCS_DIAG_OFF;
    wire wr_gen = acc && pwrite && paddr == `PMCS_GEN_CFG_OFF;
    localparam logic [14:0] CFG_RST = `PMCS_ADC_CFG_RST;
    logic [1:0] last_ch_reg;
    logic [7:0] dly_reg;
    logic pend_reg;
    logic [31:0] wait_reg;
    logic [11:3] ct_reg;
    logic srst_q;
    // soft reset also zeroes the delay, so track it here too
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ch_reg <= 2'h0;
            dly_reg <= 8'h00;
            pend_reg <= 1'b0;
            wait_reg <= 32'h0000_0000;
            ct_reg <= CFG_RST[11:3];
            srst_q <= 1'b0;
        end else begin
            if (conv_start) begin
                last_ch_reg <= conv_channel;
                pend_reg <= 1'b0;
            end
            if (wr_gen) begin
                dly_reg <= pwdata[15] ? 8'h00 : pwdata[13:6];
            end
            // soft reset lands one cycle after its write
            srst_q <= wr_gen && pwdata[15];
            if (srst_q) begin
                ct_reg <= CFG_RST[11:3];
            end else if (wr_adc) begin
                ct_reg <= pwdata[11:3];
            end
            if (wr_run || (wr_gen && pwdata[15])) begin
                pend_reg <= 1'b1;
                wait_reg <= 32'h0000_0000;
            end else if (wait_reg != 32'hFFFF_FFFF) begin
                wait_reg <= wait_reg + 32'h0000_0001;
            end
        end
    end
    wire [2:0] exp_code = conv_channel == 2'h2 ? ct_reg[5:3] :
        (conv_channel == 2'h3 ? ct_reg[8:6] : ct_reg[11:9]);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // idle long enough that no late ready set is in flight
    sequence idle_s;
        !conv_busy [*4];
    endsequence
    sequence temp_start_s;
        conv_start && conv_channel == 2'h2;
    endsequence
    temp_first_a: assert property (conv_start && conv_channel == 2'h3 |-> last_ch_reg == 2'h2)
        else $error("shunt conversion not preceded by temperature");
    busy_span_a: assert property (conv_start |-> conv_busy [*8])
        else $error("busy dropped early in a conversion");
    period_hold_a: assert property (conv_start |=> ($stable(conv_period) && $stable(conv_channel)) [*8])
        else $error("period or channel moved in a conversion");
    diag_clear_a: assert property (idle_s ##1 (rd_diag && !conv_busy) |=> !conversion_ready_flag)
        else $error("ready not cleared by status read");
    write_clear_a: assert property (idle_s ##1 (wr_run && !conv_busy) |=> !conversion_ready_flag)
        else $error("ready not cleared by mode write");
    shutdown_keep_a: assert property (idle_s ##1 (wr_sd && conversion_ready_flag) |=> conversion_ready_flag)
        else $error("ready cleared by shutdown write");
    shutdown_quiet_a: assert property (wr_sd |-> ##2 !conv_start [*8])
        else $error("conversion started in shutdown");
    mode_restart_a: assert property (wr_run && pwdata[13] && dly_reg == 8'h00 |-> ##[1:6] temp_start_s)
        else $error("mode write did not restart with temperature");
    delay_span_a: assert property (conv_start && pend_reg |-> wait_reg >= dly_reg * DLY_CYC && wait_reg <= dly_reg * DLY_CYC + 8)
        else $error("start delay length wrong");
    period_code_a: assert property (conv_start |-> conv_period == exp_code)
        else $error("period code does not match its input");
endmodule // pmcs_seq_asserts

bind pmcs_seq pmcs_seq_asserts #(.CYC_PER_US(CYC_PER_US), .US_PER_MS(US_PER_MS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_period(conv_period), .conv_busy(conv_busy),
    .conversion_ready_flag(conversion_ready_flag));
`default_nettype wire

// [verification/pmcs_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmcs_adc_model #(
    parameter DW = 20,
    parameter [DW-1:0] TMP_V = 20'h00100,
    parameter [DW-1:0] SH_V = 20'h01000,
    parameter [DW-1:0] BUS_V = 20'h00800
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // converter front end
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    input wire logic conv_busy,
    output logic signed [DW-1:0] adc_data
);
    logic [DW-1:0] val_reg;
    logic tgl_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_reg <= '0;
            tgl_reg <= 1'b0;
        end else begin
            tgl_reg <= !tgl_reg;
            if (conv_start) begin
                val_reg <= conv_channel == 2'h2 ? TMP_V : conv_channel == 2'h3 ? SH_V : BUS_V;
            end
        end
    end
    // outside a conversion the data is junk that moves every cycle
    assign adc_data = conv_busy ? val_reg : ~val_reg ^ {DW{tgl_reg}};
endmodule // pmcs_adc_model
`default_nettype wire

// [verification/pmcs_seq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_consts.vh"
module pmcs_seq_tb;
    localparam [15:0] CPU = 16'd2;
    localparam [15:0] UPM = 16'd3;
    localparam int DLY = 2 * UPM * CPU;
    localparam [31:0] TMP_V = 32'h00000100;
    localparam [31:0] SH_V = 32'h00001000;
    localparam [31:0] BUS_V = 32'h00000800;
    localparam [31:0] EXP_CUR = SH_V - ((TMP_V * 32'h10) >> 8);
    localparam [31:0] EXP_PWR = (EXP_CUR * BUS_V) >> 8;
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] avg;
        logic [4:0] n_tmp;
        logic [4:0] n_bus;
    } pmcs_row_t;
    pmcs_row_t rows [7] = '{{3'h3, 3'h0, 5'd1, 5'd1}, {3'h2, 3'h0, 5'd1, 5'd0},
        {3'h1, 3'h0, 5'd0, 5'd1}, {3'h7, 3'h1, 5'd4, 5'd4}, {3'h6, 3'h0, 5'd1, 5'd0},
        {3'h5, 3'h0, 5'd0, 5'd1}, {3'h3, 3'h2, 5'd16, 5'd16}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic err_seen;
    logic [31:0] rd;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire conv_start;
    wire [1:0] conv_channel;
    wire [2:0] conv_period;
    wire conv_busy;
    wire signed [19:0] adc_data;
    wire conversion_ready_flag;
    int n_fail = 0;
    int total_checks = 0;
    int cnt [4] = '{0, 0, 0, 0};
    int i;
    int k;
    always #5 pclk = ~pclk;
    pmcs_seq #(.CYC_PER_US(CPU), .US_PER_MS(UPM)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_period(conv_period), .conv_busy(conv_busy),
        .adc_data(adc_data), .conversion_ready_flag(conversion_ready_flag));
    pmcs_adc_model #(.TMP_V(TMP_V[19:0]), .SH_V(SH_V[19:0]), .BUS_V(BUS_V[19:0])) u_adc (
        .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_busy(conv_busy), .adc_data(adc_data));
    always @(posedge pclk) begin
        if (conv_start === 1'b1) begin
            cnt[conv_channel] <= cnt[conv_channel] + 1;
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic wait_rdy(input int lim);
        int n;
        n = 0;
        while (conversion_ready_flag !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("ready_flag", 32'h1, {31'h0, conversion_ready_flag});
    endtask
    function automatic logic [31:0] near(input int got, input int exp, input logic cont);
        return {31'h0, got == exp || (cont && got == exp + 1)};
    endfunction
    task automatic results();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        results();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("gen_rst", `PMCS_GEN_CFG_OFF, 32'h0);
        rdchk("adc_rst", `PMCS_ADC_CFG_OFF, 32'h7B68);
        apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h0);
        repeat (3) @(posedge pclk);
        for (i = 0; i < 7; i++) begin
            cnt = '{0, 0, 0, 0};
            apb(1'b1, `PMCS_ADC_CFG_OFF, {17'h0, rows[i].mode, 9'h0, rows[i].avg});
            wait_rdy(20000);
            // triggered runs must stay quiet once done
            if (!rows[i].mode[2]) repeat (300) @(posedge pclk);
            chk("temp_cnt", 32'h1, near(cnt[2], rows[i].n_tmp, rows[i].mode[2]));
            chk("shunt_cnt", 32'h1, near(cnt[3], rows[i].n_tmp, rows[i].mode[2]));
            chk("bus_cnt", 32'h1, near(cnt[0], rows[i].n_bus, rows[i].mode[2]));
            if (rows[i].n_tmp > 0) rdchk("current", `PMCS_CUR_OFF, EXP_CUR);
            if (rows[i].n_tmp > 0) rdchk("temp", `PMCS_TEMP_OFF, TMP_V);
            if (rows[i].n_bus > 0) rdchk("bus", `PMCS_VBUS_OFF, BUS_V);
            if (rows[i].n_tmp * rows[i].n_bus > 0) rdchk("power", `PMCS_PWR_OFF, EXP_PWR);
            apb(1'b0, `PMCS_ENERGY_OFF, 32'h0);
            if (rows[i].mode[2]) chk("energy_live", 32'h1, {31'h0, rd != 32'h0});
            apb(1'b0, `PMCS_DIAG_OFF, 32'h0);
            chk("ready_bit", 32'h1, {31'h0, rd[1]});
            chk("invalid", {31'h0, !rows[i].mode[2]}, {31'h0, rd[5]});
            apb(1'b0, `PMCS_DIAG_OFF, 32'h0);
            chk("ready_rd_clr", 32'h0, {31'h0, rd[1]});
            apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h0);
            repeat (3) @(posedge pclk);
        end
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err_seen});
        chk("unmapped_rd", 32'h0, rd);
        // start delay of three steps on a bus-only single run
        apb(1'b1, `PMCS_GEN_CFG_OFF, 32'h000000C0);
        cnt = '{0, 0, 0, 0};
        apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h00001000);
        k = 0;
        while (cnt[0] == 0 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        chk("delay_len", 32'h1, {31'h0, k >= 3 * DLY && k <= 3 * DLY + 8});
        wait_rdy(2000);
        apb(1'b1, `PMCS_GEN_CFG_OFF, 32'h0);
        // long continuous run, cut short by a fast single run
        apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h00007FA8);
        repeat (200) @(posedge pclk);
        rdchk("held_current", `PMCS_CUR_OFF, EXP_CUR);
        cnt = '{0, 0, 0, 0};
        apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h00003000);
        wait_rdy(2000);
        chk("abort_cnt", 32'h3, cnt[0] + cnt[2] + cnt[3]);
        repeat (10) @(posedge pclk);
        apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h0);
        apb(1'b0, `PMCS_DIAG_OFF, 32'h0);
        chk("ready_sd_kept", 32'h1, {31'h0, rd[1]});
        apb(1'b1, `PMCS_ADC_CFG_OFF, 32'h00003000);
        apb(1'b0, `PMCS_DIAG_OFF, 32'h0);
        chk("ready_wr_clr", 32'h0, {31'h0, rd[1]});
        wait_rdy(2000);
        apb(1'b1, `PMCS_GEN_CFG_OFF, 32'h000080C0);
        repeat (3) @(posedge pclk);
        rdchk("srst_adc", `PMCS_ADC_CFG_OFF, 32'h7B68);
        rdchk("srst_gen", `PMCS_GEN_CFG_OFF, 32'h0);
        results();
    end
endmodule // pmcs_seq_tb
`default_nettype wire
